// [pkg/efc_pkg.sv]
// shared constants for the error flag classifier
package efc_pkg;
    // --------------------------------------------------------------
    // register map (byte offsets on the bus, one word apart but for the gap before ADDR_DETAIL0)
    // --------------------------------------------------------------
    localparam logic [7:0] ADDR_FLAGS   = 8'h00;
    localparam logic [7:0] ADDR_CTRL    = 8'h04;
    localparam logic [7:0] ADDR_LEDS    = 8'h08;
    localparam logic [7:0] ADDR_DETAIL0 = 8'h20;
    localparam logic [7:0] ADDR_DETAIL7 = 8'h3C;

    // --------------------------------------------------------------
    // flag word bit positions
    // --------------------------------------------------------------
    localparam int BIT_SUM     = 10;
    localparam int BIT_FATAL   = 11;
    localparam int BIT_SERIOUS = 12;
    localparam int BIT_LIGHT   = 13;
    localparam int BIT_WARNING = 14;

    // control register bits (write one = pulse)
    localparam int CTRL_START    = 0;
    localparam int CTRL_COLD     = 1;
    localparam int CTRL_BUSACK   = 2;

    localparam int NUM_CLASSES   = 4;
    localparam int NUM_DETAIL    = 8;
    localparam int DETAIL_W      = 16;

    // severity classes
    typedef enum logic [3:0] {
        CLS_FATAL   = 4'h1,
        CLS_SERIOUS = 4'h2,
        CLS_LIGHT   = 4'h4,
        CLS_WARNING = 4'h8
    } efc_class_t;

    localparam logic [3:0] CLASS_RESET = 4'h0;
    localparam logic [15:0] DETAIL_RESET = 16'h0000;
endpackage

// [src/efc_sync_edge.sv]
// rising edge detector for the run/stop selector
`timescale 1ns/1ps
`default_nettype none
module efc_sync_edge (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic level,
    output logic      rise
);
    logic last;
    logic next_last;

    always_comb begin
        next_last = level;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last <= 1'b0;
        end else begin
            last <= next_last;
        end
    end

    assign rise = level & ~last;
endmodule
`default_nettype wire

// [src/efc_detail_store.sv]
// eight error detail words, written by bus or by a new error
`timescale 1ns/1ps
`default_nettype none
module efc_detail_store #(
    parameter int WIDTH = efc_pkg::DETAIL_W,
    parameter int DEPTH = efc_pkg::NUM_DETAIL
) (
    input  wire logic                     clk,
    input  wire logic                     reset_n,
    input  wire logic                     busWrite,
    input  wire logic [2:0]               busIndex,
    input  wire logic [WIDTH-1:0]         busData,
    input  wire logic                     errLoad,
    input  wire logic [DEPTH*WIDTH-1:0]   errInfo,
    input  wire logic [2:0]               readIndex,
    output logic      [WIDTH-1:0]         readData
);
    logic [WIDTH-1:0] words      [DEPTH];
    logic [WIDTH-1:0] next_words [DEPTH];

    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            next_words[i] = words[i];
            if (errLoad) begin
                next_words[i] = errInfo[i*WIDTH +: WIDTH];
            end else if (busWrite && busIndex == i[2:0]) begin
                next_words[i] = busData;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                words[i] <= efc_pkg::DETAIL_RESET;
            end
        end else begin
            for (int i = 0; i < DEPTH; i++) begin
                words[i] <= next_words[i];
            end
        end
    end

    assign readData = words[readIndex];
endmodule
`default_nettype wire

// [src/efc_error_flags.sv]
// error flag classifier with wishbone register access
//
// Local design decisions: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module efc_error_flags #(
    parameter int DW = efc_pkg::DETAIL_W
) (
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [31:0]          wb_dat_i,
    input  wire logic [3:0]           wb_sel_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // error detection
    input  wire logic                 errValid,
    input  wire logic [3:0]           errClass,
    input  wire logic                 errIsBus,
    input  wire logic [8*DW-1:0]      errInfo,
    input  wire logic                 errPresent,
    input  wire logic                 errPresentBus,
    // operator events
    input  wire logic                 runSelect,
    input  wire logic                 programStart,
    // outputs
    output logic      [3:0]           classLed,
    output logic                      sumFlag,
    output logic                      remoteClear
);
    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic        access;
    logic        wr;
    logic        ackQ;
    logic        next_ackQ;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    logic        isDetail;
    logic [2:0]  detIdx;
    logic [DW-1:0] detData;

    assign access   = wb_cyc_i & wb_stb_i & ~ackQ;
    assign wr       = access & wb_we_i & wb_sel_i[0] & wb_sel_i[1];
    assign isDetail = (wb_adr_i >= efc_pkg::ADDR_DETAIL0)
                    && (wb_adr_i <= efc_pkg::ADDR_DETAIL7);
    assign detIdx   = wb_adr_i[4:2];

    // ------------------------------------------------------------------
    // control pulses
    // ------------------------------------------------------------------
    logic runRise;
    logic ctrlWr;
    logic startCmd;
    logic coldCmd;
    logic busAckCmd;
    logic flagsWr;
    logic lightZeroWr;
    logic [3:0] ledMask;
    logic [3:0] next_ledMask;

    efc_sync_edge u_run (
        .clk     (clk),
        .reset_n (reset_n),
        .level   (runSelect),
        .rise    (runRise)
    );

    assign ctrlWr    = wr && (wb_adr_i == efc_pkg::ADDR_CTRL);
    assign startCmd  = (ctrlWr && wb_dat_i[efc_pkg::CTRL_START]) || programStart;
    assign coldCmd   = ctrlWr && wb_dat_i[efc_pkg::CTRL_COLD];
    assign busAckCmd = ctrlWr && wb_dat_i[efc_pkg::CTRL_BUSACK];
    assign flagsWr   = wr && (wb_adr_i == efc_pkg::ADDR_FLAGS);
    assign lightZeroWr = flagsWr && !wb_dat_i[efc_pkg::BIT_LIGHT];

    // ------------------------------------------------------------------
    // class flags
    // ------------------------------------------------------------------
    logic [3:0] classFlag;
    logic [3:0] next_classFlag;
    logic       busErrStored;
    logic       next_busErrStored;
    logic       globalAck;
    logic       busAckHit;
    logic       remoteQ;
    logic       next_remoteQ;

    assign globalAck = startCmd | coldCmd | runRise;
    assign busAckHit = busAckCmd & busErrStored;

    always_comb begin
        next_classFlag    = classFlag;
        next_busErrStored = busErrStored;
        next_remoteQ      = busAckHit;
        if (globalAck || lightZeroWr) begin
            next_classFlag[2] = 1'b0;
        end
        if (busAckHit) begin
            next_classFlag[2] = 1'b0;
            next_busErrStored = 1'b0;
        end
        if (globalAck || lightZeroWr) begin
            next_busErrStored = 1'b0;
        end
        // persisting errors set again after acknowledge
        if (errPresent) begin
            next_classFlag[2] = 1'b1;
        end
        if (errPresentBus) begin
            next_classFlag[2] = 1'b1;
            next_busErrStored = 1'b1;
        end
        if (errValid) begin
            next_classFlag = next_classFlag | errClass;
            if (errIsBus) begin
                next_busErrStored = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            classFlag    <= efc_pkg::CLASS_RESET;
            busErrStored <= 1'b0;
            remoteQ      <= 1'b0;
        end else begin
            classFlag    <= next_classFlag;
            busErrStored <= next_busErrStored;
            remoteQ      <= next_remoteQ;
        end
    end

    // ------------------------------------------------------------------
    // leds: lit by a flag, blanked on acknowledge until a new error
    // ------------------------------------------------------------------
    always_comb begin
        next_ledMask = ledMask;
        if (globalAck || lightZeroWr || busAckHit) begin
            next_ledMask = 4'hF;
        end
        if (errValid) begin
            next_ledMask = next_ledMask & ~errClass;
        end
        if (errPresent || errPresentBus) begin
            next_ledMask[2] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ledMask <= 4'h0;
        end else begin
            ledMask <= next_ledMask;
        end
    end

    assign classLed    = classFlag & ~ledMask;
    assign sumFlag     = |classFlag;
    assign remoteClear = remoteQ;

    // ------------------------------------------------------------------
    // detail words
    // ------------------------------------------------------------------
    efc_detail_store #(
        .WIDTH (DW),
        .DEPTH (efc_pkg::NUM_DETAIL)
    ) u_detail (
        .clk       (clk),
        .reset_n   (reset_n),
        .busWrite  (wr && isDetail),
        .busIndex  (detIdx),
        .busData   (wb_dat_i[DW-1:0]),
        .errLoad   (errValid),
        .errInfo   (errInfo),
        .readIndex (detIdx),
        .readData  (detData)
    );

    // ------------------------------------------------------------------
    // read path and ack
    // ------------------------------------------------------------------
    always_comb begin
        next_ackQ  = access;
        next_rdata = rdata;
        if (access && !wb_we_i) begin
            if (wb_adr_i == efc_pkg::ADDR_FLAGS) begin
                next_rdata = '0;
                next_rdata[efc_pkg::BIT_SUM]     = sumFlag;
                next_rdata[efc_pkg::BIT_FATAL]   = classFlag[0];
                next_rdata[efc_pkg::BIT_SERIOUS] = classFlag[1];
                next_rdata[efc_pkg::BIT_LIGHT]   = classFlag[2];
                next_rdata[efc_pkg::BIT_WARNING] = classFlag[3];
            end else if (wb_adr_i == efc_pkg::ADDR_LEDS) begin
                next_rdata = {28'h0000000, classLed};
            end else if (isDetail) begin
                next_rdata = {16'h0000, detData};
            end else begin
                next_rdata = 32'h00000000;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ackQ  <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ackQ  <= next_ackQ;
            rdata <= next_rdata;
        end
    end

    assign wb_ack_o = ackQ;
    assign wb_dat_o = rdata;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    sum_tracks_a: assert property (@(posedge clk) disable iff (!reset_n)
        (access && !wb_we_i && wb_adr_i == efc_pkg::ADDR_FLAGS) |=>
        (wb_dat_o[efc_pkg::BIT_SUM]
            == (wb_dat_o[efc_pkg::BIT_WARNING:efc_pkg::BIT_FATAL] != 4'h0)))
        else $error("sum flag wrong");
    new_err_a: assert property (@(posedge clk) disable iff (!reset_n)
        errValid |=> ((classFlag & $past(errClass)) == $past(errClass)))
        else $error("new error not flagged");
    ack_clears_a: assert property (@(posedge clk) disable iff (!reset_n)
        (globalAck && !errValid && !errPresent && !errPresentBus) |=> !classFlag[2])
        else $error("light flag not cleared");
    zero_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        (lightZeroWr && !errValid && !errPresent && !errPresentBus) |=> !classFlag[2])
        else $error("zero write ignored");
    bus_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        (busAckCmd && !busErrStored) |=> !remoteClear)
        else $error("bus ack without bus error");
    led_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        (globalAck && !errValid && !errPresent && !errPresentBus) |=> classLed == 4'h0)
        else $error("leds stay on");
    persist_a: assert property (@(posedge clk) disable iff (!reset_n)
        errPresent |=> classFlag[2]) else $error("persisting error lost");
    remote_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        busAckHit |=> remoteClear ##1 !remoteClear)
        else $error("remote clear not one pulse");
    wb_ack_a: assert property (@(posedge clk) disable iff (!reset_n)
        access |=> wb_ack_o ##1 !wb_ack_o) else $error("ack timing");
endmodule
`default_nettype wire

// [sim/efc_remote_model.sv]
// behavioural model of a remote module storing its own errors
`timescale 1ns/1ps
`default_nettype none
module efc_remote_model #(
    parameter int HOLD_CYCLES = 8
) (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic remoteClear,
    input  wire logic setErr,
    input  wire logic testButton,
    input  wire logic terminalCmd,
    output logic      storedErr
);
    int holdCount;
    // long press, bus-error ack or terminal command clear the store
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            storedErr <= 1'b0;
            holdCount <= 0;
        end else begin
            holdCount <= testButton ? holdCount + 1 : 0;
            if (setErr)
                storedErr <= 1'b1;
            else if (remoteClear || terminalCmd || holdCount >= HOLD_CYCLES - 1)
                storedErr <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [sim/efc_error_flags_tb.sv]
// self-checking bench of the error flag classifier
`timescale 1ns/1ps
`default_nettype none
module efc_error_flags_tb;
    logic         clk = 0, resetN = 0, cyc = 0, stb = 0, we = 0, errValid = 0;
    logic         errIsBus = 0, errPresent = 0, runSelect = 0, programStart = 0;
    logic         btn = 0, termCmd = 0, setErr = 0, errPresentBus = 0;
    logic [7:0]   adr = 8'h00;
    logic [31:0]  wdat = 32'h0, rd;
    logic [3:0]   errClass = 4'h0;
    logic [127:0] info = '0;
    wire logic [31:0] wbDat;
    wire logic [3:0]  classLed;
    wire logic        wbAck, sumFlag, remoteClear, storedErr;
    int fails = 0, checks = 0, seed = 32'hac59, rcCount = 0;

    always #5 clk = ~clk;
    always @(posedge clk) if (remoteClear === 1'b1) rcCount++;

    efc_error_flags i_dut (.clk(clk), .reset_n(resetN), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_dat_o(wbDat),
        .wb_ack_o(wbAck), .errValid(errValid), .errClass(errClass), .errIsBus(errIsBus),
        .errInfo(info), .errPresent(errPresent), .errPresentBus(errPresentBus),
        .runSelect(runSelect),
        .programStart(programStart), .classLed(classLed), .sumFlag(sumFlag),
        .remoteClear(remoteClear));
    efc_remote_model i_remote (.clk(clk), .reset_n(resetN), .remoteClear(remoteClear),
        .setErr(setErr), .testButton(btn), .terminalCmd(termCmd), .storedErr(storedErr));

    function automatic logic [31:0] expFlags(input logic [3:0] cls);
        logic [31:0] f;
        f = 32'h0;
        f[efc_pkg::BIT_WARNING:efc_pkg::BIT_FATAL] = cls;
        f[efc_pkg::BIT_SUM] = |cls;
        return f;
    endfunction

    task automatic report_and_stop();
        if (fails == 0 && checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (wbAck !== 1'b1 && n < 20);
        rd = wbDat;
        if (n >= 20) fails++;
        cyc <= 1'b0;
        stb <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic rst();
        resetN <= 1'b0;
        repeat (6) @(posedge clk);
        resetN <= 1'b1;
        @(posedge clk);
    endtask

    task automatic raise(input logic [3:0] cls, input logic bus);
        errClass <= cls;
        errIsBus <= bus;
        info <= {$random(seed), $random(seed), $random(seed), $random(seed)};
        errValid <= 1'b1;
        setErr <= bus;
        @(posedge clk);
        errValid <= 1'b0;
        setErr <= 1'b0;
        repeat (2) @(posedge clk);
    endtask

    task automatic readFlags(input logic [3:0] cls);
        wb(1'b0, efc_pkg::ADDR_FLAGS, 32'h0);
        chk(rd, expFlags(cls));
        chk({28'h0, classLed}, {28'h0, cls});
    endtask

    initial begin
        #300000;
        fails++;
        report_and_stop();
    end

    initial begin
        int rcOld;
        rst();
        readFlags(4'h0);
        wb(1'b0, 8'hF0, 32'h0);
        chk(rd, 32'h0);
        // every acknowledge source clears the light flag and its led
        for (int m = 0; m < 6; m++) begin
            raise(efc_pkg::CLS_LIGHT, m == 5);
            readFlags(4'h4);
            rcOld = rcCount;
            case (m)
                0: wb(1'b1, efc_pkg::ADDR_FLAGS, 32'h0);
                1: wb(1'b1, efc_pkg::ADDR_CTRL, 32'h1);
                2: wb(1'b1, efc_pkg::ADDR_CTRL, 32'h2);
                3: begin
                    programStart <= 1'b1;
                    @(posedge clk);
                    programStart <= 1'b0;
                end
                4: begin
                    runSelect <= 1'b1;
                    repeat (3) @(posedge clk);
                    runSelect <= 1'b0;
                end
                default: wb(1'b1, efc_pkg::ADDR_CTRL, 32'h4);
            endcase
            repeat (4) @(posedge clk);
            readFlags(4'h0);
            chk(rcCount - rcOld, (m == 5) ? 1 : 0);
            chk(storedErr, 1'b0);
            for (int i = 0; i < 8; i++) begin
                wb(1'b0, efc_pkg::ADDR_DETAIL0 + 8'(4 * i), 32'h0);
                chk(rd, {16'h0, info[16*i +: 16]});
            end
        end
        // bus-error ack leaves an error off the system bus alone
        raise(efc_pkg::CLS_LIGHT, 1'b0);
        rcOld = rcCount;
        wb(1'b1, efc_pkg::ADDR_CTRL, 32'h4);
        repeat (3) @(posedge clk);
        readFlags(4'h4);
        chk(rcCount - rcOld, 0);
        // a lasting condition sets the flag again
        errPresent <= 1'b1;
        errPresentBus <= 1'b1;
        wb(1'b1, efc_pkg::ADDR_FLAGS, 32'h0);
        readFlags(4'h4);
        errPresent <= 1'b0;
        errPresentBus <= 1'b0;
        wb(1'b1, efc_pkg::ADDR_FLAGS, 32'h0);
        readFlags(4'h0);
        // new error beats a clear in the same cycle
        errClass <= efc_pkg::CLS_LIGHT;
        errValid <= 1'b1;
        programStart <= 1'b1;
        @(posedge clk);
        errValid <= 1'b0;
        programStart <= 1'b0;
        repeat (2) @(posedge clk);
        readFlags(4'h4);
        // remote store cleared by long button press and terminal command
        setErr <= 1'b1;
        @(posedge clk);
        setErr <= 1'b0;
        btn <= 1'b1;
        repeat (10) @(posedge clk);
        btn <= 1'b0;
        chk(storedErr, 1'b0);
        setErr <= 1'b1;
        @(posedge clk);
        setErr <= 1'b0;
        @(posedge clk);
        chk(storedErr, 1'b1);
        termCmd <= 1'b1;
        @(posedge clk);
        termCmd <= 1'b0;
        repeat (2) @(posedge clk);
        chk(storedErr, 1'b0);
        // each class keeps its own flag
        for (int c = 0; c < 4; c++) begin
            rst();
            raise(4'(1 << c), 1'b0);
            readFlags(4'(1 << c));
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
